// >>> logic/spmc_pkg.sv
// spmc_pkg: shared constants of the sensor power and mode command block
// assumes: both ends and the bench refer to it by scoped names only
package spmc_pkg;
  // two-wire slave address of the device end (arbitrary value)
  localparam logic [6:0] DEV_ADDR       = 7'h2a;
  // command codes carried in the register address byte
  localparam logic [7:0] CMD_WAKE       = 8'h04;
  localparam logic [7:0] CMD_SLEEP      = 8'h05;
  localparam logic [7:0] CMD_SETTINGS   = 8'h07;
  localparam logic [7:0] CMD_CSENSE     = 8'h08;
  localparam logic [3:0] CMD_INSEL_HI   = 4'h1;
  // sensor_supply_settings layout and reset value
  localparam int         VSEL_BIT       = 0;
  localparam int         SLEEP_OFF_BIT  = 1;
  localparam logic [7:0] SETTINGS_RST   = 8'h00;
  localparam logic [7:0] SETTINGS_MASK  = 8'h03;
  // host register map, byte addresses
  localparam logic [3:0] HREG_CMD       = 4'h0;
  localparam logic [3:0] HREG_STATUS    = 4'h4;
  localparam logic [3:0] HREG_RDATA     = 4'h8;
  // host command word and status register fields
  localparam int         CMDW_REG_LSB   = 0;
  localparam int         CMDW_DATA_LSB  = 8;
  localparam int         CMDW_HAS_DATA  = 16;
  localparam int         CMDW_READ      = 17;
  localparam int         STAT_BUSY      = 0;
  localparam int         STAT_NACK      = 1;
  // serial clock timing
  localparam int         CLK_PERIOD_NS  = 50;
  localparam int         SCL_PERIOD_NS  = 10000;
  localparam int         QUARTER_CYC    = (SCL_PERIOD_NS / 4) / CLK_PERIOD_NS;
endpackage

// >>> logic/spmc_link_if.sv
// spmc_link_if: two-wire link between host end and device end
// assumes: both lines pulled up; level resolved here from the enables
`timescale 1ns/1ps
interface spmc_link_if;
  logic scl_host_out;
  logic scl_host_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // open drain: a driver pulls low only, otherwise the pull-up wins
  assign scl = ~(scl_host_oe & ~scl_host_out);
  assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));

  modport dev  (input scl, sda, output sda_dev_out, sda_dev_oe);
  modport host (input scl, sda, output scl_host_out, scl_host_oe, sda_host_out, sda_host_oe);
endinterface

// >>> logic/spmc_dev.sv
// spmc_dev: device end, two-wire command slave for supply and mode control
// assumes: link lines come from another domain and are synchronised here
// Behaviour
// - supply defaults to 3V after power-up
// - regulator always on while awake
// - address 0x07 then one byte sets regulator
// - bit 0 selects 3V or 2.65V
// - bit 1 selects regulator off in sleep
// - address 0x08 enters current-sense mode
// - input select 0x10-0x1F cancels current sense
// - address 0x05 enters sleep, analog off
// - configuration kept across sleep
// - asleep, only 0x04 and 0x07 act
// - asleep, retained registers still readable
// - address 0x04 wakes, analog back on
// - device awake after power-up
// - settings byte acknowledged, then host stops
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
module spmc_dev (
  input  wire logic     clk_i,
  input  wire logic     sys_rst_i,
  input  wire logic     ce_i,
  spmc_link_if.dev      link,
  output logic          supply_voltage_select_bit_o,
  output logic          sleep_supply_off_bit_o,
  output logic          regulator_on_o,
  output logic          analog_enable_o,
  output logic          current_sense_o,
  output logic          sleeping_o,
  output logic [7:0]    settings_o
);
  typedef enum logic [5:0] {
    B_IDLE  = 6'b000001,
    B_ADDR  = 6'b000010,
    B_CMD   = 6'b000100,
    B_PARAM = 6'b001000,
    B_READ  = 6'b010000,
    B_SKIP  = 6'b100000
  } spmc_byte_t;

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  spmc_byte_t byte_q;
  spmc_byte_t next_q;
  logic [3:0] bitcnt_q;
  logic       in_ack_q;
  logic [7:0] sh_q;
  logic       sda_oe_q;
  logic [7:0] settings_q;
  logic       sleep_q;
  logic       csense_q;
  logic       cmd_strobe;
  logic       param_strobe;

  // two flops per line before any logic looks at them
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (ce_i) begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_rise   = ce_i & scl_sync_q[1] & ~scl_prev_q;
  assign scl_fall   = ce_i & ~scl_sync_q[1] & scl_prev_q;
  assign start_cond = ce_i & scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
  assign stop_cond  = ce_i & scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

  // byte-complete events, at the falling edge that opens the ack slot
  assign cmd_strobe   = scl_fall & ~in_ack_q & (bitcnt_q == 4'h8) & (byte_q == B_CMD);
  assign param_strobe = scl_fall & ~in_ack_q & (bitcnt_q == 4'h8) & (byte_q == B_PARAM);

  // bit and byte sequencing
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      byte_q   <= B_IDLE;
      next_q   <= B_IDLE;
      bitcnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      sh_q     <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (start_cond) begin
      byte_q   <= B_ADDR;
      bitcnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_cond) begin
      byte_q   <= B_IDLE;
      in_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (scl_rise && !in_ack_q && bitcnt_q < 4'h8 && byte_q != B_IDLE) begin
      bitcnt_q <= bitcnt_q + 4'h1;
      if (byte_q != B_READ) begin
        sh_q <= {sh_q[6:0], sda_sync_q[1]};
      end
    end else if (scl_fall && byte_q != B_IDLE) begin
      if (in_ack_q) begin
        in_ack_q <= 1'b0;
        bitcnt_q <= 4'h0;
        byte_q   <= next_q;
        if (next_q == B_READ && byte_q != B_READ) begin
          sh_q     <= settings_q;
          sda_oe_q <= ~settings_q[7];
        end else begin
          sda_oe_q <= 1'b0;
        end
      end else if (bitcnt_q == 4'h8) begin
        in_ack_q <= 1'b1;
        unique case (byte_q)
          B_ADDR: begin
            sda_oe_q <= (sh_q[7:1] == spmc_pkg::DEV_ADDR);
            if (sh_q[7:1] != spmc_pkg::DEV_ADDR) begin
              next_q <= B_IDLE;
            end else if (sh_q[0]) begin
              next_q <= B_READ;
            end else begin
              next_q <= B_CMD;
            end
          end
          B_CMD: begin
            sda_oe_q <= 1'b1;
            if (sh_q == spmc_pkg::CMD_SETTINGS) begin
              next_q <= B_PARAM;
            end else begin
              next_q <= B_SKIP;
            end
          end
          B_PARAM: begin
            sda_oe_q <= 1'b1;
            next_q   <= B_SKIP;
          end
          B_READ: begin
            sda_oe_q <= 1'b0;
            next_q   <= B_IDLE;
          end
          default: begin
            sda_oe_q <= 1'b1;
            next_q   <= B_SKIP;
          end
        endcase
      end else if (byte_q == B_READ && !in_ack_q) begin
        sh_q     <= {sh_q[6:0], 1'b0};
        sda_oe_q <= ~sh_q[6];
      end
    end
  end

  // regulator settings; only the two low bits are kept
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      settings_q <= spmc_pkg::SETTINGS_RST;
    end else if (param_strobe) begin
      settings_q <= sh_q & spmc_pkg::SETTINGS_MASK;
    end
  end

  // sleep state; only wake acts while asleep
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleep_q <= 1'b0;
    end else if (cmd_strobe) begin
      if (sh_q == spmc_pkg::CMD_WAKE) begin
        sleep_q <= 1'b0;
      end else if (sh_q == spmc_pkg::CMD_SLEEP && !sleep_q) begin
        sleep_q <= 1'b1;
      end
    end
  end

  // current-sense mode, survives sleep; commands filtered while asleep
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      csense_q <= 1'b0;
    end else if (cmd_strobe && !sleep_q) begin
      if (sh_q == spmc_pkg::CMD_CSENSE) begin
        csense_q <= 1'b1;
      end else if (sh_q[7:4] == spmc_pkg::CMD_INSEL_HI) begin
        csense_q <= 1'b0;
      end
    end
  end

  // registered outputs; settings untouched by sleep entry or exit
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      supply_voltage_select_bit_o <= 1'b0;
      sleep_supply_off_bit_o      <= 1'b0;
      regulator_on_o              <= 1'b1;
      analog_enable_o             <= 1'b1;
      current_sense_o             <= 1'b0;
      sleeping_o                  <= 1'b0;
      settings_o                  <= spmc_pkg::SETTINGS_RST;
    end else if (ce_i) begin
      supply_voltage_select_bit_o <= settings_q[spmc_pkg::VSEL_BIT];
      sleep_supply_off_bit_o      <= settings_q[spmc_pkg::SLEEP_OFF_BIT];
      regulator_on_o  <= ~sleep_q | ~settings_q[spmc_pkg::SLEEP_OFF_BIT];
      analog_enable_o             <= ~sleep_q;
      current_sense_o             <= csense_q;
      sleeping_o                  <= sleep_q;
      settings_o                  <= settings_q;
    end
  end

  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe  = sda_oe_q;
endmodule

// >>> logic/spmc_host.sv
// spmc_host: host end, Avalon-MM command registers driving a two-wire master
// assumes: single master on the link; the device never stretches the clock
`timescale 1ns/1ps
module spmc_host (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  spmc_link_if.host        link
);
  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_START = 5'b00010,
    H_BITS  = 5'b00100,
    H_STOP  = 5'b01000,
    H_DONE  = 5'b10000
  } spmc_hstate_t;

  localparam logic [7:0] QMAX = 8'(spmc_pkg::QUARTER_CYC - 1);

  spmc_hstate_t st_q;
  logic [7:0]   tick_cnt_q;
  logic         tick;
  logic [1:0]   ph_q;
  logic [3:0]   bit_q;
  logic [1:0]   idx_q;
  logic [8:0]   tx_q;
  logic [8:0]   rx_q;
  logic         rd_q;
  logic         has_data_q;
  logic [7:0]   reg_q;
  logic [7:0]   data_q;
  logic [7:0]   rdata_q;
  logic         nack_q;
  logic         ack_q;
  logic         cmd_go;
  logic [1:0]   sda_sync_q;
  logic [1:0]   last_idx;

  function automatic logic [7:0] byte_at(input logic [1:0] i, input logic rd,
                                         input logic [7:0] r, input logic [7:0] d);
    byte_at = (i == 2'h0) ? {spmc_pkg::DEV_ADDR, rd} :
              (i == 2'h1) ? (rd ? 8'hff : r) : d;
  endfunction

  // avalon slave: one wait cycle, then answer
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign cmd_go = ce_i & ack_q & avs_write_i & (avs_address_i == spmc_pkg::HREG_CMD) &
                  (st_q == H_IDLE);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q          <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
      if (avs_read_i && !ack_q) begin
        unique case (avs_address_i)
          spmc_pkg::HREG_STATUS: avs_readdata_o <= {30'h0, nack_q, st_q != H_IDLE};
          spmc_pkg::HREG_RDATA:  avs_readdata_o <= {24'h0, rdata_q};
          default:               avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // quarter-period tick, only while a transfer runs
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_q <= 8'h00;
    end else if (ce_i) begin
      tick_cnt_q <= (st_q == H_IDLE || tick) ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end
  assign tick = ce_i & (tick_cnt_q == QMAX);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_sync_q <= 2'h3;
    end else if (ce_i) begin
      sda_sync_q <= {sda_sync_q[0], link.sda};
    end
  end

  assign last_idx = rd_q ? 2'h1 : (has_data_q ? 2'h2 : 2'h1);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= H_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      tx_q <= 9'h1ff;
      rx_q <= 9'h000;
      rd_q <= 1'b0;
      has_data_q <= 1'b0;
      reg_q <= 8'h00;
      data_q <= 8'h00;
      rdata_q <= 8'h00;
      nack_q <= 1'b0;
    end else if (cmd_go) begin
      rd_q       <= avs_writedata_i[spmc_pkg::CMDW_READ];
      has_data_q <= avs_writedata_i[spmc_pkg::CMDW_HAS_DATA];
      reg_q      <= avs_writedata_i[spmc_pkg::CMDW_REG_LSB +: 8];
      data_q     <= avs_writedata_i[spmc_pkg::CMDW_DATA_LSB +: 8];
      tx_q       <= {spmc_pkg::DEV_ADDR, avs_writedata_i[spmc_pkg::CMDW_READ], 1'b1};
      idx_q      <= 2'h0;
      bit_q      <= 4'h0;
      ph_q       <= 2'h0;
      nack_q     <= 1'b0;
      st_q       <= H_START;
    end else if (tick) begin
      ph_q <= ph_q + 2'h1;
      unique case (st_q)
        H_START: if (ph_q == 2'h3) st_q <= H_BITS;
        H_BITS: begin
          if (ph_q == 2'h2) rx_q <= {rx_q[7:0], sda_sync_q[1]};
          if (ph_q == 2'h3) begin
            if (bit_q != 4'h8) begin
              bit_q <= bit_q + 4'h1;
              tx_q  <= {tx_q[7:0], 1'b1};
            end else if (rx_q[0] && !(rd_q && idx_q == 2'h1)) begin
              nack_q <= 1'b1;
              st_q   <= H_STOP;
            end else if (idx_q == last_idx) begin
              if (rd_q) rdata_q <= rx_q[8:1];
              st_q <= H_STOP;
            end else begin
              bit_q <= 4'h0;
              idx_q <= idx_q + 2'h1;
              tx_q  <= {byte_at(idx_q + 2'h1, rd_q, reg_q, data_q), 1'b1};
            end
          end
        end
        H_STOP: if (ph_q == 2'h3) st_q <= H_DONE;
        H_DONE: st_q <= H_IDLE;
        default: st_q <= H_IDLE;
      endcase
    end else if (ce_i && st_q == H_DONE) begin
      st_q <= H_IDLE;
    end
  end

  // line levels from state and phase, sda data bits from tx_q; oe high means pull low
  assign link.scl_host_out = 1'b0;
  assign link.sda_host_out = 1'b0;
  assign link.scl_host_oe  = ((st_q == H_START) && ph_q == 2'h3) ||
                             ((st_q == H_BITS) && (ph_q == 2'h0 || ph_q == 2'h3)) ||
                             ((st_q == H_STOP) && ph_q == 2'h0);
  assign link.sda_host_oe  = ((st_q == H_START) && ph_q != 2'h0) ||
                             ((st_q == H_BITS) && !tx_q[8]) ||
                             ((st_q == H_STOP) && ph_q != 2'h2 && ph_q != 2'h3);
endmodule

// >>> tb/spmc_chk.sv
// spmc_chk: concurrent checks on the link and the device outputs
// assumes: one clock domain, inputs wired by name beside the link
`timescale 1ns/1ps
module spmc_chk (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       scl,
  input wire logic       sda_dev_oe,
  input wire logic       supply_voltage_select_bit_o,
  input wire logic       sleep_supply_off_bit_o,
  input wire logic       regulator_on_o,
  input wire logic       analog_enable_o,
  input wire logic       current_sense_o,
  input wire logic       sleeping_o,
  input wire logic [7:0] settings_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_power_up: assert property ($fell(sys_rst_i) |-> !sleeping_o && regulator_on_o
    && !supply_voltage_select_bit_o && !current_sense_o) else $error("bad power-up state");
  chk_awake_reg_on: assert property ((!sleeping_o)[*3] |-> regulator_on_o)
    else $error("regulator off while awake");
  chk_sleep_supply: assert property ((sleeping_o && $stable(sleep_supply_off_bit_o))[*3]
    |-> regulator_on_o == !sleep_supply_off_bit_o) else $error("sleep supply wrong");
  chk_field_follow: assert property ($stable(settings_o)[*3] |->
    supply_voltage_select_bit_o == settings_o[0] && sleep_supply_off_bit_o == settings_o[1])
    else $error("settings fields not on outputs");
  chk_analog_sleep: assert property ($stable(sleeping_o)[*2] |->
    analog_enable_o == !sleeping_o) else $error("analog enable wrong");
  chk_keep_settings: assert property ($changed(sleeping_o) |-> $stable(settings_o))
    else $error("settings lost at sleep change");
  chk_csense_asleep: assert property ($rose(current_sense_o) |-> !$past(sleeping_o))
    else $error("current sense entered asleep");
  chk_upper_zero: assert property (settings_o[7:2] == 6'h00)
    else $error("settings upper bits set");
  chk_ack_window: assert property ($rose(sda_dev_oe) |-> !scl ##1 sda_dev_oe[*8])
    else $error("ack not held low");
  chk_update_ack: assert property ($changed(settings_o) |-> sda_dev_oe)
    else $error("settings changed outside ack");

  cover property ($rose(sleeping_o));
  cover property ($fell(current_sense_o));
  cover property ($rose(supply_voltage_select_bit_o));
endmodule

// >>> tb/sensor_power_mode_commands_tb_top.sv
// sensor_power_mode_commands_tb_top: host and device joined, driven over avalon
// assumes: 20 MHz clock, host ce and device ce held high
`timescale 1ns/1ps
module sensor_power_mode_commands_tb_top;
  localparam int TMO = 95000;
  logic        clk_i           = 1'b0;
  logic        sys_rst_i       = 1'b1;
  logic [3:0]  avs_address_i   = 4'h0;
  logic        avs_read_i      = 1'b0;
  logic        avs_write_i     = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        vsel_o, soff_o, reg_on_o, ana_o, cs_o, slp_o;
  logic [7:0]  set_o;
  logic [31:0] rd;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  spmc_link_if spmc_link_if_i ();
  spmc_dev spmc_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .link(spmc_link_if_i),
    .supply_voltage_select_bit_o(vsel_o), .sleep_supply_off_bit_o(soff_o),
    .regulator_on_o(reg_on_o), .analog_enable_o(ana_o), .current_sense_o(cs_o),
    .sleeping_o(slp_o), .settings_o(set_o));
  spmc_host spmc_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .link(spmc_link_if_i));
  spmc_chk spmc_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl(spmc_link_if_i.scl),
    .sda_dev_oe(spmc_link_if_i.sda_dev_oe), .supply_voltage_select_bit_o(vsel_o),
    .sleep_supply_off_bit_o(soff_o), .regulator_on_o(reg_on_o), .analog_enable_o(ana_o),
    .current_sense_o(cs_o), .sleeping_o(slp_o), .settings_o(set_o));

  always #25 clk_i = ~clk_i;

  task complete_run;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      num_errors = num_errors + 1;
    end
  endtask

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
           output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= wd;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  // one command on the link, then wait for the host to go idle
  task cmd(input logic [7:0] c, input logic [7:0] d, input logic hd, input logic rdb);
    bus(1'b1, spmc_pkg::HREG_CMD, {14'h0, rdb, hd, d, c}, rd);
    do bus(1'b0, spmc_pkg::HREG_STATUS, 32'h0, rd); while (rd[spmc_pkg::STAT_BUSY] !== 1'b0);
    check("status", 32'h0, rd);
  endtask

  task readback(input logic [7:0] exp);
    cmd(spmc_pkg::CMD_SETTINGS, 8'h00, 1'b0, 1'b1);
    bus(1'b0, spmc_pkg::HREG_RDATA, 32'h0, rd);
    check("rdata", {24'h0, exp}, rd);
  endtask

  task outs(input logic [7:0] s, input logic sl, input logic cs);
    check("settings", s, set_o);
    check("vsel", s[0], vsel_o);
    check("sleep_off", s[1], soff_o);
    check("sleeping", sl, slp_o);
    check("analog", !sl, ana_o);
    check("csense", cs, cs_o);
    check("reg_on", !(sl & s[1]), reg_on_o);
  endtask

  task t_powerup;
    outs(8'h00, 1'b0, 1'b0);
    bus(1'b0, 4'hc, 32'h0, rd);
    check("unmapped", 32'h0, rd);
  endtask

  task t_settings;
    cmd(spmc_pkg::CMD_SETTINGS, 8'hfd, 1'b1, 1'b0);
    outs(8'h01, 1'b0, 1'b0);
    readback(8'h01);
  endtask

  task t_csense;
    cmd(spmc_pkg::CMD_CSENSE, 8'h00, 1'b0, 1'b0);
    outs(8'h01, 1'b0, 1'b1);
    cmd(8'h20, 8'h00, 1'b0, 1'b0);
    outs(8'h01, 1'b0, 1'b1);
    cmd(8'h1f, 8'h00, 1'b0, 1'b0);
    outs(8'h01, 1'b0, 1'b0);
    cmd(spmc_pkg::CMD_CSENSE, 8'h00, 1'b0, 1'b0);
    cmd(8'h10, 8'h00, 1'b0, 1'b0);
    outs(8'h01, 1'b0, 1'b0);
  endtask

  task t_sleep;
    cmd(spmc_pkg::CMD_SETTINGS, 8'h03, 1'b1, 1'b0);
    outs(8'h03, 1'b0, 1'b0);
    cmd(spmc_pkg::CMD_SLEEP, 8'h00, 1'b0, 1'b0);
    outs(8'h03, 1'b1, 1'b0);
    cmd(spmc_pkg::CMD_CSENSE, 8'h00, 1'b0, 1'b0);
    outs(8'h03, 1'b1, 1'b0);
    cmd(spmc_pkg::CMD_SETTINGS, 8'h01, 1'b1, 1'b0);
    outs(8'h01, 1'b1, 1'b0);
    readback(8'h01);
    cmd(spmc_pkg::CMD_WAKE, 8'h00, 1'b0, 1'b0);
    outs(8'h01, 1'b0, 1'b0);
  endtask

  // input select ignored asleep, then a mid-run reset restores defaults
  task t_reset;
    cmd(spmc_pkg::CMD_CSENSE, 8'h00, 1'b0, 1'b0);
    cmd(spmc_pkg::CMD_SLEEP, 8'h00, 1'b0, 1'b0);
    cmd(8'h10, 8'h00, 1'b0, 1'b0);
    outs(8'h01, 1'b1, 1'b1);
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    outs(8'h00, 1'b0, 1'b0);
    readback(8'h00);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_powerup();
    t_settings();
    t_csense();
    t_sleep();
    t_reset();
    complete_run();
  end
endmodule
